// File: testbench/can_event_irq_power_stamp_tb.sv
/*
 Self-checking bench for the CAN event, power and time-stamp block.
 Assumes the defines header and latch model.
*/
`timescale 1ns/100ps
`include "can_event_defines.svh"
// ==========================================
// Bench top
module can_event_irq_power_stamp_tb;
   logic aclk = 1'h0, aresetn = 1'h0, irq_en = 1'h0, vector_taken;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, rx_err_count = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic tx_done = 1'h0, rx_store = 1'h0, rx_to_fifo = 1'h0, fifo_one_free = 1'h0;
   logic rx_invalid = 1'h0, frame_valid_eof = 1'h0, engine_tx = 1'h0, cpu_sleep = 1'h0, cpu_idle = 1'h0;
   logic bus_receive_pin = 1'h1, capture_pin_two = 1'h0;
   logic [2:0] tx_buf = 3'h0;
   logic [4:0] rx_buf = 5'h00;
   logic [8:0] tx_err_count = 9'h000;
   logic bus_transmit_pin, capture_channel_two, cpu_event_request, module_stopped, module_disabled;
   logic [8:0] tc [6] = '{9'h05f, 9'h060, 9'h07f, 9'h080, 9'h100, 9'h000};
   logic [7:0] rc [6] = '{8'h00, 8'h00, 8'h60, 8'h7f, 8'h80, 8'h00};
   logic [15:0] ef [6] = '{16'h0000, 16'h0110, 16'h0310, 16'h0610, 16'h1c10, 16'h0000};
   int mismatches = 0, cmp_count = 0;

   can_event_irq_power_stamp can_event_irq_power_stamp_i (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .tx_done(tx_done), .tx_buf(tx_buf), .rx_store(rx_store),
      .rx_buf(rx_buf), .rx_to_fifo(rx_to_fifo), .fifo_one_free(fifo_one_free), .rx_invalid(rx_invalid),
      .frame_valid_eof(frame_valid_eof), .tx_err_count(tx_err_count), .rx_err_count(rx_err_count),
      .engine_tx(engine_tx), .cpu_sleep(cpu_sleep), .cpu_idle(cpu_idle), .bus_receive_pin(bus_receive_pin),
      .capture_pin_two(capture_pin_two), .bus_transmit_pin(bus_transmit_pin),
      .capture_channel_two(capture_channel_two), .cpu_event_request(cpu_event_request),
      .module_stopped(module_stopped), .module_disabled(module_disabled));
   cpu_irq_model cpu_irq_model_i (.aclk(aclk), .aresetn(aresetn), .cpu_event_request(cpu_event_request),
      .cpu_event_request_enable(irq_en), .vector_taken(vector_taken));

   // Free running 50 MHz clock.
   always #10 aclk = ~aclk;

   // Compare one value and count it.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Print the verdict and stop.
   task automatic end_of_test();
      if (mismatches == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Wait cycles, then sample at the falling edge.
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
      @(negedge aclk);
   endtask

   // One AXI4-Lite transfer.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      logic ha, hw, hd;
      @(posedge aclk);
      if (w) begin
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'h1;
         wvalid <= 1'h1;
         bready <= 1'h1;
      end else begin
         araddr <= a;
         arvalid <= 1'h1;
         rready <= 1'h1;
      end
      for (n = 0; n < 60; n++) begin
         @(negedge aclk);
         ha = w ? awvalid && awready : arvalid && arready;
         hw = wvalid && wready;
         hd = w ? bvalid : rvalid;
         q = w ? {30'h0, bresp} : rdata;
         @(posedge aclk);
         if (ha) begin
            awvalid <= 1'h0;
            arvalid <= 1'h0;
         end
         if (hw)
            wvalid <= 1'h0;
         if (hd) begin
            bready <= 1'h0;
            rready <= 1'h0;
            break;
         end
      end
      if (n == 60) begin
         mismatches++;
         end_of_test();
      end
   endtask

   // Write, and checked read.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'h1, a, d, q);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'h0, a, 32'h0, q);
      chk(q, exp);
   endtask

   // One stored reception.
   task automatic rx_ev(input logic [4:0] b, input logic f);
      @(posedge aclk);
      rx_store <= 1'h1;
      rx_buf <= b;
      rx_to_fifo <= f;
      fifo_one_free <= f;
      @(posedge aclk);
      rx_store <= 1'h0;
      cyc(3);
   endtask

   // Reset values.
   task automatic t_reset();
      logic [31:0] q;
      rdchk(`OFF_CODE, {25'h0, `CODE_NONE});
      rdchk(`OFF_BITTIME, 32'h32);
      bus(1'h1, 8'h40, 32'h7f, q);
      chk(q, {30'h0, `RESP_SLVERR});
      rdchk(`OFF_ENABLE, 32'h0);
   endtask

   // Transmit flag, masking, code and clearing.
   task automatic t_tx();
      @(posedge aclk);
      tx_done <= 1'h1;
      tx_buf <= 3'h7;
      @(posedge aclk);
      tx_done <= 1'h0;
      cyc(3);
      chk(cpu_event_request, 1'h0);
      rdchk(`OFF_FLAG, 32'h1);
      rdchk(`OFF_CODE, {25'h0, `CODE_NONE});
      wr(`OFF_ENABLE, 32'h7f);
      cyc(3);
      chk(vector_taken, 1'h1);
      rdchk(`OFF_CODE, {25'h0, `CODE_TX_BASE + 7'h7});
      wr(`OFF_FLAG, 32'h1);
      cyc(3);
      chk(cpu_event_request, 1'h0);
   endtask

   // Receive-side sources.
   task automatic t_rx();
      rx_ev(5'h1f, 1'h0);
      rdchk(`OFF_FULL, 32'h80000000);
      rdchk(`OFF_CODE, {25'h0, `CODE_RX_BASE + 7'h1f});
      rx_ev(5'h1f, 1'h0);
      rdchk(`OFF_OVF, 32'h80000000);
      rdchk(`OFF_CODE, {25'h0, `CODE_OVF_BASE + 7'h1f});
      rx_ev(5'h02, 1'h1);
      rdchk(`OFF_FLAG, 32'h0e);
      wr(`OFF_ENABLE, 32'h08);
      rdchk(`OFF_CODE, {25'h0, `CODE_FIFO});
      wr(`OFF_ENABLE, 32'h7f);
      wr(`OFF_FLAG, 32'h7f);
      @(posedge aclk);
      rx_invalid <= 1'h1;
      @(posedge aclk);
      rx_invalid <= 1'h0;
      rdchk(`OFF_CODE, {25'h0, `CODE_INV});
   endtask

   // Error states over a counter table.
   task automatic t_err();
      for (int i = 0; i < 6; i++) begin
         wr(`OFF_FLAG, 32'h7f);
         @(posedge aclk);
         tx_err_count <= tc[i];
         rx_err_count <= rc[i];
         cyc(3);
         rdchk(`OFF_FLAG, {16'h0, ef[i]});
      end
   endtask

   // Wake in Sleep only, filtered, then disabled.
   task automatic t_wake();
      @(posedge aclk);
      bus_receive_pin <= 1'h0;
      cyc(30);
      chk(module_disabled, 1'h0);
      wr(`OFF_CFG2, 32'h4000);
      @(posedge aclk);
      bus_receive_pin <= 1'h1;
      cpu_sleep <= 1'h1;
      cyc(4);
      chk(bus_transmit_pin, 1'h1);
      @(posedge aclk);
      bus_receive_pin <= 1'h0;
      cyc(10);
      @(posedge aclk);
      bus_receive_pin <= 1'h1;
      cyc(8);
      chk(module_disabled, 1'h0);
      @(posedge aclk);
      bus_receive_pin <= 1'h0;
      cyc(40);
      chk(module_disabled, 1'h1);
      @(posedge aclk);
      bus_receive_pin <= 1'h1;
      cpu_sleep <= 1'h0;
      cyc(4);
      chk(cpu_event_request, 1'h1);
      rdchk(`OFF_CODE, {25'h0, `CODE_WAKE});
      wr(`OFF_ENABLE, 32'h5f);
      cyc(2);
      chk(cpu_event_request, 1'h0);
      chk(module_disabled, 1'h1);
      wr(`OFF_CTRL1, 32'h1);
      cyc(2);
      chk(module_disabled, 1'h0);
   endtask

   // Idle stops only with stop-in-idle.
   task automatic t_idle(input logic [31:0] ctl, input logic exp);
      wr(`OFF_CTRL1, ctl);
      @(posedge aclk);
      cpu_idle <= 1'h1;
      cyc(4);
      chk(module_stopped, exp);
      chk(bus_transmit_pin, exp);
      @(posedge aclk);
      cpu_idle <= 1'h0;
   endtask

   // Count capture pulse cycles.
   task automatic t_stamp(input logic [31:0] ctl, input int exp);
      int c;
      c = 0;
      wr(`OFF_CTRL1, ctl);
      @(posedge aclk);
      capture_pin_two <= 1'h1;
      frame_valid_eof <= 1'h1;
      @(posedge aclk);
      frame_valid_eof <= 1'h0;
      repeat (70) begin
         @(negedge aclk);
         c += int'(capture_channel_two);
      end
      chk(c, exp);
      @(posedge aclk);
      capture_pin_two <= 1'h0;
   endtask

   // Reset, then all scenarios.
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      irq_en <= 1'h1;
      t_reset();
      t_tx();
      t_rx();
      t_err();
      t_wake();
      t_idle(32'h0, 1'h0);
      t_idle(32'h2000, 1'h1);
      t_stamp(32'h8, 50);
      t_stamp(32'h0, 66);
      end_of_test();
   end
endmodule

// File: testbench/cpu_irq_model.sv
/*
 CPU interrupt latch behind the event request.
 Assumes a level request on aclk.
*/
`timescale 1ns/100ps
// ==========================================
// CPU interrupt latch
module cpu_irq_model (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Request, enable and service
   input wire logic cpu_event_request,
   input wire logic cpu_event_request_enable,
   output logic vector_taken
);
   logic cpu_event_request_flag_reg;
   // flag held until reset
   // Latches the request until cleared.
   always_ff @(posedge aclk) begin
      if (!aresetn)
         cpu_event_request_flag_reg <= 1'h0;
      else if (cpu_event_request)
         cpu_event_request_flag_reg <= 1'h1;
   end
   // vector on flag and enable
   // Vectors on flag and enable.
   assign vector_taken = cpu_event_request_flag_reg & cpu_event_request_enable;
endmodule

// File: verilog/can_event_defines.svh
/*
 Offsets, field positions, reset values, event codes and timing counts
 of the CAN event, power and time-stamp block.
 Assumes a 50 MHz clock and a byte-addressed AXI4-Lite register window.
*/
`ifndef CAN_EVENT_DEFINES_SVH
`define CAN_EVENT_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define OFF_FLAG 8'h00
`define OFF_ENABLE 8'h04
`define OFF_CODE 8'h08
`define OFF_CTRL1 8'h0c
`define OFF_CFG2 8'h10
`define OFF_BITTIME 8'h14
`define OFF_FULL 8'h18
`define OFF_OVF 8'h1c

// ==========================================================
// Event flag positions
`define FLAG_TX 0
`define FLAG_RX 1
`define FLAG_OVF 2
`define FLAG_FIFO 3
`define FLAG_ERR 4
`define FLAG_WAKE 5
`define FLAG_INV 6
`define STATE_LSB 8
`define ST_TX_WARNING_STATE 0
`define ST_RX_WARNING_STATE 1
`define ST_TX_PASSIVE_STATE 2
`define ST_RX_PASSIVE_STATE 3
`define ST_TX_BUSOFF_STATE 4

// ==========================================================
// Control fields
`define CTRL_REEN 0
`define CTRL_CAPEN 3
`define CTRL_IDLESTOP 13
`define CFG2_WAKFILT 14

// ==========================================================
// Error counter limits
`define WARN_LO 9'h060
`define WARN_HI 9'h07f
`define PASSIVE_LIM 9'h080
`define BUSOFF_LIM 9'h100

// ==========================================================
// Event codes
`define CODE_TX_BASE 7'h00
`define CODE_RX_BASE 7'h20
`define CODE_OVF_BASE 7'h40
`define CODE_ERR 7'h60
`define CODE_WAKE 7'h61
`define CODE_INV 7'h62
`define CODE_FIFO 7'h63
`define CODE_NONE 7'h7f

// ==========================================================
// Timing
`define CLK_PERIOD_NS 20
`define WAKE_FILT_NS 500
`define WAKE_FILT_CYC ((`WAKE_FILT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BIT_TIME_NS 1000
`define BIT_TIME_CYC (`BIT_TIME_NS / `CLK_PERIOD_NS)

// ==========================================================
// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: verilog/can_event_irq_power_stamp.sv
/*
 Event flag aggregation, low-power handling and receive time-stamp pulse of
 a CAN controller, with an AXI4-Lite register slave.
 Assumes the protocol engine supplies single-cycle event pulses and error
 counter values on aclk, and that aclk keeps running for wake detection.
*/
// Overview of operation
// - Seven event flags, each with enable bit.
// - Request only when flag and enable match.
// - Code reports highest-priority enabled active flag.
// - Five error states set one error flag.
// - Transmit done sets flag, code names buffer.
// - Flags stay set until software clears.
// - Full bit first, then receive flag.
// - Full buffer sets overflow bit, then flag.
// - One free FIFO buffer sets FIFO flag.
// - Sleep bus activity sets wake flag.
// - Other reception errors set invalid-message flag.
// - Stopped clocks hold transmit pin recessive.
// - Idle stops module only with stop-in-idle.
// - Module stays disabled after wake until re-enabled.
// - Wake detection only while in Sleep.
// - Wake filter rejects short receive glitches.
// - One bit-time capture pulse after frame.
// - Capture pulse only while capture enabled.
// - Capture channel two: pulse when capture enabled, else pin two.
// - Warning states track counters 96 to 127.
// - Passive states track counters from 128.
// - Bus-off state at transmit count 256.
`timescale 1ns/100ps
`include "can_event_defines.svh"

module can_event_irq_power_stamp import can_event_pkg::*; (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write channels
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read channels
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Protocol engine events
   input wire logic tx_done,
   input wire logic [2:0] tx_buf,
   input wire logic rx_store,
   input wire logic [4:0] rx_buf,
   input wire logic rx_to_fifo,
   input wire logic fifo_one_free,
   input wire logic rx_invalid,
   input wire logic frame_valid_eof,
   input wire logic [8:0] tx_err_count,
   input wire logic [7:0] rx_err_count,
   input wire logic engine_tx,
   // CPU power state
   input wire logic cpu_sleep,
   input wire logic cpu_idle,
   // Pins and capture
   input wire logic bus_receive_pin,
   input wire logic capture_pin_two,
   output logic bus_transmit_pin,
   output logic capture_channel_two,
   // Interrupt and module state
   output logic cpu_event_request,
   output logic module_stopped,
   output logic module_disabled
);

   // ==========================================================
   // Register file and bus state
   logic [6:0] flag_reg, flag_next, en_reg;
   logic [4:0] state_reg, state_next;
   logic [31:0] ctrl_reg, cfg2_reg, full_reg, full_next, ovf_reg, ovf_next;
   logic [15:0] bit_time_reg;
   code_t code_reg;
   logic [2:0] tx_idx_reg;
   logic [4:0] rx_idx_reg, ovf_idx_reg;
   logic rx_pend_reg, ovf_pend_reg, fifo_pend_reg;
   logic aw_have_reg, w_have_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg, w_mask_reg;
   power_state_t pwr_reg, pwr_next;

   // Byte strobes widened to a bit mask.
   function automatic logic [31:0] strobe_mask(input logic [3:0] s);
      strobe_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   // priority err, wake, ovf, tx, rx, fifo, invalid.
   function automatic code_t pick_code(input logic [6:0] act, input logic [2:0] t,
                                       input logic [4:0] r, input logic [4:0] o);
      if (act[`FLAG_ERR])
         pick_code = `CODE_ERR;
      else if (act[`FLAG_WAKE])
         pick_code = `CODE_WAKE;
      else if (act[`FLAG_OVF])
         pick_code = `CODE_OVF_BASE | {2'h0, o};
      else if (act[`FLAG_TX])
         pick_code = `CODE_TX_BASE | {4'h0, t};
      else if (act[`FLAG_RX])
         pick_code = `CODE_RX_BASE | {2'h0, r};
      else if (act[`FLAG_FIFO])
         pick_code = `CODE_FIFO;
      else if (act[`FLAG_INV])
         pick_code = `CODE_INV;
      else
         pick_code = `CODE_NONE;
   endfunction

   // ==========================================================
   // Bus write decode
   wire wr_go = aw_have_reg && w_have_reg && !bvalid;
   wire [31:0] wr_bits = w_data_reg & w_mask_reg;
   wire wr_flag = wr_go && aw_addr_reg == `OFF_FLAG;
   wire wr_en = wr_go && aw_addr_reg == `OFF_ENABLE;
   wire wr_ctrl = wr_go && aw_addr_reg == `OFF_CTRL1;
   wire wr_cfg2 = wr_go && aw_addr_reg == `OFF_CFG2;
   wire wr_bt = wr_go && aw_addr_reg == `OFF_BITTIME;
   wire wr_full = wr_go && aw_addr_reg == `OFF_FULL;
   wire wr_ovf = wr_go && aw_addr_reg == `OFF_OVF;
   wire wr_known = wr_flag || wr_en || wr_ctrl || wr_cfg2 || wr_bt || wr_full || wr_ovf
                   || (wr_go && aw_addr_reg == `OFF_CODE);
   wire [6:0] flag_clr_w = wr_flag ? wr_bits[6:0] : 7'h00;
   wire [31:0] full_clr_w = wr_full ? wr_bits : 32'h0;
   wire [31:0] ovf_clr_w = wr_ovf ? wr_bits : 32'h0;
   wire reenable_w = wr_ctrl && wr_bits[`CTRL_REEN];

   // Bus read decode.
   wire [31:0] flag_view = {19'h0, state_reg, 1'b0, flag_reg};
   wire rd_known = araddr == `OFF_FLAG || araddr == `OFF_ENABLE || araddr == `OFF_CODE
                   || araddr == `OFF_CTRL1 || araddr == `OFF_CFG2 || araddr == `OFF_BITTIME
                   || araddr == `OFF_FULL || araddr == `OFF_OVF;
   wire [31:0] rd_mux =
      araddr == `OFF_FLAG ? flag_view :
      araddr == `OFF_ENABLE ? {25'h0, en_reg} :
      araddr == `OFF_CODE ? {25'h0, code_reg} :
      araddr == `OFF_CTRL1 ? ctrl_reg :
      araddr == `OFF_CFG2 ? cfg2_reg :
      araddr == `OFF_BITTIME ? {16'h0, bit_time_reg} :
      araddr == `OFF_FULL ? full_reg :
      araddr == `OFF_OVF ? ovf_reg : 32'h0;
   wire ar_go = arvalid && arready;

   // Write address and data are held apart until both have arrived.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0;
         w_mask_reg <= 32'h0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= awaddr;
         end else if (wr_go) begin
            aw_have_reg <= 1'b0;
         end
         if (wvalid && wready) begin
            w_have_reg <= 1'b1;
            w_data_reg <= wdata;
            w_mask_reg <= strobe_mask(wstrb);
         end else if (wr_go) begin
            w_have_reg <= 1'b0;
         end
         awready <= !aw_have_reg && !(awvalid && awready) && !bvalid;
         wready <= !w_have_reg && !(wvalid && wready) && !bvalid;
         if (wr_go) begin
            bvalid <= 1'b1;
            bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // Read answer one cycle after the address is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= `RESP_OKAY;
      end else begin
         arready <= !rvalid && !ar_go;
         if (ar_go) begin
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Pin synchronisers
   logic rx_s1, rx_s2, rx_s3, rx_level_reg;
   logic ic_s1, ic_s2, ic_s3, ic_level_reg;

   // A pin level is taken once the second and third stages agree.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {rx_s1, rx_s2, rx_s3, rx_level_reg} <= 4'hf;
         {ic_s1, ic_s2, ic_s3, ic_level_reg} <= 4'h0;
      end else begin
         {rx_s1, rx_s2, rx_s3} <= {bus_receive_pin, rx_s1, rx_s2};
         {ic_s1, ic_s2, ic_s3} <= {capture_pin_two, ic_s1, ic_s2};
         rx_level_reg <= (rx_s2 == rx_s3) ? rx_s3 : rx_level_reg;
         ic_level_reg <= (ic_s2 == ic_s3) ? ic_s3 : ic_level_reg;
      end
   end

   // ==========================================================
   // Power state
   logic clocks_off;
   assign pwr_next = cpu_sleep ? PWR_SLEEP :
                     (cpu_idle && ctrl_reg[`CTRL_IDLESTOP]) ? PWR_IDLE_STOP : PWR_RUN;

   // Clocks count as stopped in Sleep and in Idle with the stop option.
   always_comb begin
      case (pwr_reg)
         PWR_RUN: clocks_off = 1'b0;
         PWR_IDLE_STOP: clocks_off = 1'b1;
         PWR_SLEEP: clocks_off = 1'b1;
         default: clocks_off = 1'b1;
      endcase
   end

   // ==========================================================
   // Wake detection with optional glitch filter
   logic [4:0] filt_cnt_reg;
   wire in_sleep = pwr_reg == PWR_SLEEP;
   wire filt_done = filt_cnt_reg == 5'(`WAKE_FILT_CYC);
   wire dom_seen = cfg2_reg[`CFG2_WAKFILT] ? filt_done : !rx_level_reg;
   wire wake_hit = in_sleep && dom_seen;

   // Counts dominant cycles asleep; recessive restarts it.
   always_ff @(posedge aclk) begin
      if (!aresetn || !in_sleep || rx_level_reg)
         filt_cnt_reg <= 5'h00;
      else if (!filt_done)
         filt_cnt_reg <= filt_cnt_reg + 5'h01;
   end

   // ==========================================================
   // Error states
   // warning windows
   assign state_next[`ST_TX_WARNING_STATE] = tx_err_count >= `WARN_LO && tx_err_count <= `WARN_HI;
   assign state_next[`ST_RX_WARNING_STATE] = {1'b0, rx_err_count} >= `WARN_LO && {1'b0, rx_err_count} <= `WARN_HI;
   assign state_next[`ST_TX_PASSIVE_STATE] = tx_err_count >= `PASSIVE_LIM;
   assign state_next[`ST_RX_PASSIVE_STATE] = {1'b0, rx_err_count} >= `PASSIVE_LIM;
   assign state_next[`ST_TX_BUSOFF_STATE] = tx_err_count >= `BUSOFF_LIM;

   // ==========================================================
   // Event sources and sticky flags
   logic [6:0] set_vec;
   wire rx_hit_full = full_reg[rx_buf];
   assign set_vec[`FLAG_TX] = tx_done;
   assign set_vec[`FLAG_RX] = rx_pend_reg;
   assign set_vec[`FLAG_OVF] = ovf_pend_reg;
   assign set_vec[`FLAG_FIFO] = fifo_pend_reg;
   assign set_vec[`FLAG_ERR] = |(state_next & ~state_reg);
   assign set_vec[`FLAG_WAKE] = wake_hit;
   assign set_vec[`FLAG_INV] = rx_invalid;
   assign flag_next = (flag_reg & ~flag_clr_w) | set_vec;

   // Per-buffer full and overflow bits; a hardware set beats a clear.
   genvar gi;
   generate
      for (gi = 0; gi < 32; gi++) begin : g_buf
         wire hit = rx_store && rx_buf == 5'(gi);
         assign full_next[gi] = (full_reg[gi] && !full_clr_w[gi]) || (hit && !rx_hit_full);
         assign ovf_next[gi] = (ovf_reg[gi] && !ovf_clr_w[gi]) || (hit && rx_hit_full);
      end
   endgenerate

   // Buffer bits are set first, the flags a cycle later; error states set with their flag.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         full_reg <= 32'h0;
         ovf_reg <= 32'h0;
         state_reg <= 5'h00;
         rx_pend_reg <= 1'b0;
         ovf_pend_reg <= 1'b0;
         fifo_pend_reg <= 1'b0;
      end else begin
         full_reg <= full_next;
         ovf_reg <= ovf_next;
         state_reg <= state_next;
         rx_pend_reg <= rx_store && !rx_hit_full;
         ovf_pend_reg <= rx_store && rx_hit_full;
         fifo_pend_reg <= rx_store && !rx_hit_full && rx_to_fifo && fifo_one_free;
      end
   end

   // Flags, buffer indices and the event code.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag_reg <= 7'h00;
         tx_idx_reg <= 3'h0;
         rx_idx_reg <= 5'h00;
         ovf_idx_reg <= 5'h00;
         code_reg <= `CODE_NONE;
      end else begin
         flag_reg <= flag_next;
         if (tx_done)
            tx_idx_reg <= tx_buf;
         if (rx_store && !rx_hit_full)
            rx_idx_reg <= rx_buf;
         if (rx_store && rx_hit_full)
            ovf_idx_reg <= rx_buf;
         code_reg <= pick_code(flag_reg & en_reg, tx_idx_reg, rx_idx_reg, ovf_idx_reg);
      end
   end

   // ==========================================================
   // Control registers written by software
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         en_reg <= 7'h00;
         ctrl_reg <= 32'h0;
         cfg2_reg <= 32'h0;
         bit_time_reg <= 16'(`BIT_TIME_CYC);
      end else begin
         if (wr_en)
            en_reg <= (en_reg & ~w_mask_reg[6:0]) | wr_bits[6:0];
         if (wr_ctrl)
            ctrl_reg <= ((ctrl_reg & ~w_mask_reg) | wr_bits) & ~(32'h1 << `CTRL_REEN);
         if (wr_cfg2)
            cfg2_reg <= (cfg2_reg & ~w_mask_reg) | wr_bits;
         if (wr_bt)
            bit_time_reg <= (bit_time_reg & ~w_mask_reg[15:0]) | wr_bits[15:0];
      end
   end

   // ==========================================================
   // Time-stamp pulse
   logic [15:0] stamp_cnt_reg, stamp_cnt_next;
   logic stamp_pulse_reg;
   wire cap_en = ctrl_reg[`CTRL_CAPEN];
   assign stamp_cnt_next = !cap_en ? 16'h0 :
                           frame_valid_eof ? bit_time_reg :
                           (stamp_cnt_reg != 16'h0) ? stamp_cnt_reg - 16'h1 : 16'h0;

   // ==========================================================
   // Registered outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwr_reg <= PWR_RUN;
         stamp_cnt_reg <= 16'h0;
         stamp_pulse_reg <= 1'b0;
         capture_channel_two <= 1'b0;
         bus_transmit_pin <= 1'b1;
         cpu_event_request <= 1'b0;
         module_stopped <= 1'b0;
         module_disabled <= 1'b0;
      end else begin
         pwr_reg <= pwr_next;
         stamp_cnt_reg <= stamp_cnt_next;
         stamp_pulse_reg <= stamp_cnt_next != 16'h0;
         capture_channel_two <= cap_en ? (stamp_cnt_next != 16'h0) : ic_level_reg;
         bus_transmit_pin <= clocks_off ? 1'b1 : engine_tx;
         cpu_event_request <= |(flag_reg & en_reg);
         module_stopped <= clocks_off;
         module_disabled <= wake_hit || (module_disabled && !reenable_w);
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_irq_has_cause: assert property (cpu_event_request |-> $past(|(flag_reg & en_reg)))
      else $error("Event request without enabled flag.");
   a_irq_follows: assert property (|(flag_reg & en_reg) |=> cpu_event_request)
      else $error("Enabled flag did not raise request.");
   a_flag_sticky: assert property ((($past(flag_reg) & ~$past(flag_clr_w)) & ~flag_reg) == 7'h00)
      else $error("Flag dropped without a clear.");
   a_tx_code: assert property (tx_done |=> flag_reg[`FLAG_TX] && tx_idx_reg == $past(tx_buf))
      else $error("Transmit flag or index wrong.");
   a_rx_order: assert property (rx_store && !rx_hit_full && !wr_full
      |=> full_reg[rx_idx_reg] && !(flag_reg[`FLAG_RX] && !$past(flag_reg[`FLAG_RX])) ##1 flag_reg[`FLAG_RX])
      else $error("Receive flag not after full bit.");
   a_ovf_order: assert property (rx_store && rx_hit_full |=> ovf_reg[ovf_idx_reg] ##1 flag_reg[`FLAG_OVF])
      else $error("Overflow flag not after overflow bit.");
   a_err_entry: assert property (state_next[`ST_TX_PASSIVE_STATE] && !state_reg[`ST_TX_PASSIVE_STATE] |=> flag_reg[`FLAG_ERR])
      else $error("Passive entry did not set error flag.");
   a_tx_recessive: assert property (clocks_off |=> bus_transmit_pin)
      else $error("Transmit pin not recessive while stopped.");
   a_wake_sleep: assert property ($rose(flag_reg[`FLAG_WAKE]) |-> $past(pwr_reg) == PWR_SLEEP)
      else $error("Wake flag set outside Sleep.");
   a_stamp_gate: assert property (!cap_en |=> !stamp_pulse_reg)
      else $error("Capture pulse while disabled.");
   a_stamp_start: assert property (frame_valid_eof && cap_en && bit_time_reg != 16'h0 ##1 cap_en
      |-> stamp_pulse_reg)
      else $error("Capture pulse did not start.");

   c_rx_event: cover property (rx_store ##2 cpu_event_request);
   c_wake: cover property (in_sleep ##1 flag_reg[`FLAG_WAKE]);
   c_stamp: cover property (cap_en && frame_valid_eof ##1 stamp_pulse_reg);

endmodule

// File: verilog/can_event_pkg.sv
/*
 Types shared by the CAN event, power and time-stamp block.
 Assumes nothing beyond the defines header.
*/
package can_event_pkg;

   // ==========================================================
   // Power state of the module
   typedef enum logic [1:0] {
      PWR_RUN,
      PWR_IDLE_STOP,
      PWR_SLEEP
   } power_state_t;

   typedef logic [6:0] code_t;

endpackage
